// ==== opc_pkg.sv ====
// package for the operator panel control block
// assumes one clock (pclk) and an apb master for software access
`default_nettype none
package opc_pkg;
  // apb register byte offsets
  localparam logic [11:0] OPC_REG_DISP = 12'h000;
  localparam logic [11:0] OPC_REG_IA = 12'h004;
  localparam logic [11:0] OPC_REG_STATUS_WORD_ONE = 12'h008;
  localparam logic [11:0] OPC_REG_STATUS_WORD_TWO = 12'h00c;
  localparam logic [11:0] OPC_REG_FAULT = 12'h010;
  localparam logic [11:0] OPC_REG_ALARM = 12'h014;
  localparam logic [11:0] OPC_REG_STAT = 12'h018;
  // status register bit positions
  localparam int OPC_STAT_RUN = 0;
  localparam int OPC_STAT_WAIT = 1;
  localparam int OPC_STAT_STEP = 2;
  localparam int OPC_STAT_LOCK = 3;
  // second status word fields cleared by the clear request
  localparam logic [31:0] OPC_STATUS_WORD_TWO_CLR_MASK = 32'h0000_01ff; // key 1:0, inhibit 4:2, ptr 8:5
  // reset values, private range top and sizes
  localparam logic [31:0] OPC_DISP_RST = 32'h0200_0000;
  localparam logic [16:0] OPC_IA_RST = 17'h0_0025;
  localparam logic [16:0] OPC_PRIV_TOP = 17'h0_000f;
  localparam int OPC_IA_W = 17;
  localparam int OPC_BLOCKS = 8;
  // momentary switch indices
  localparam int OPC_M_STEP = 0;
  localparam int OPC_M_CLR2 = 1;
  localparam int OPC_M_INS1 = 2;
  localparam int OPC_M_INS2 = 3;
  localparam int OPC_M_ST_IA = 4;
  localparam int OPC_M_ST_SEL = 5;
  localparam int OPC_M_DCLR = 6;
  localparam int OPC_M_DENT = 7;
  localparam int OPC_M_DS_IA = 8;
  localparam int OPC_M_DS_SEL = 9;
  localparam int OPC_M_INCR = 10;
  localparam int OPC_M_CPURST = 11;
  localparam int OPC_M_SYSRST = 12;
  localparam int OPC_M_INTR = 13;
  localparam int OPC_M_N = 14;

  typedef enum logic [2:0] {
    OPC_IDLE = 3'b000,
    OPC_EXEC = 3'b001,
    OPC_FETCH = 3'b010,
    OPC_STORE = 3'b011,
    OPC_HALT = 3'b100
  } opc_state_t;

  // execution result reported by the cpu datapath
  typedef struct packed {
    logic done;
    logic taken;
    logic [16:0] target;
    logic psw_we;
    logic [31:0] status_word_one;
    logic [31:0] status_word_two;
    logic opnd_valid;
    logic [16:0] opnd_addr;
  } opc_exec_t;

  // memory request toward the cpu memory path
  typedef struct packed {
    logic req;
    logic we;
    logic [16:0] addr;
    logic [31:0] wdata;
  } opc_mem_t;
endpackage : opc_pkg
`default_nettype wire

// ==== opc_panel.sv ====
// operator panel control: switches, display register, status words, sequencing
// assumes switch levels synchronous to pclk, cpu datapath and memory answer by handshake
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
module opc_panel
  import opc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [OPC_M_N-1:0] mom_sw,
  input wire logic [31:0] data_sw,
  input wire logic [16:0] sel_addr_sw,
  input wire logic run_sw,
  input wire logic hold_sw,
  input wire logic stop_sw,
  input wire logic lock_sw,
  input wire logic wdog_norm_sw,
  input wire logic ilv_norm_sw,
  input wire logic par_cont_sw,
  input wire logic clk_cont_sw,
  input wire logic [OPC_BLOCKS-1:0] par_err,
  input wire logic [OPC_BLOCKS-1:0] over_temp,
  input wire opc_pkg::opc_exec_t exec_in,
  output logic exec_start,
  output logic [31:0] exec_instr,
  output logic int_hold,
  output opc_pkg::opc_mem_t mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] disp_out,
  output logic [16:0] ia_out,
  output logic [31:0] status_word_one_out,
  output logic [31:0] status_word_two_out,
  output logic run_ind,
  output logic wait_ind,
  output logic [OPC_BLOCKS-1:0] fault_out,
  output logic alarm_out,
  output logic panel_intr,
  output logic wdog_norm,
  output logic ilv_norm,
  output logic par_cont,
  output logic clk_cont
);
  import opc_pkg::*;

  typedef struct packed {
    opc_state_t st;
    logic [31:0] disp;
    logic [31:0] status_word_one;
    logic [31:0] status_word_two;
    logic [OPC_BLOCKS-1:0] fault;
    logic alarm;
    logic step;
    logic pnl;
    logic op_hit;
    logic start;
    logic mreq;
    logic mwe;
    logic [16:0] maddr;
    logic [OPC_M_N-1:0] s1;
    logic [OPC_M_N-1:0] s2;
    logic [OPC_M_N-1:0] s3;
    logic [31:0] rdata;
  } opc_regs_t;

  opc_regs_t r_ff;
  opc_regs_t nxt_r;

  // register decode, used for the error answer (pslverr)
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == OPC_REG_DISP) || (a == OPC_REG_IA) || (a == OPC_REG_STATUS_WORD_ONE) ||
              (a == OPC_REG_STATUS_WORD_TWO) || (a == OPC_REG_FAULT) || (a == OPC_REG_ALARM) ||
              (a == OPC_REG_STAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // derived levels
  logic [OPC_M_N-1:0] ev;
  logic lock;
  logic run_eff;
  logic pnl_ok;
  logic stop_hit;
  logic [16:0] ia;
  logic rst_ev;
  logic apb_acc;
  logic [31:0] stat_w;

  assign ev = r_ff.s2 & ~r_ff.s3;
  assign lock = lock_sw;
  assign run_eff = lock | run_sw;
  assign pnl_ok = (r_ff.st == OPC_IDLE) && !lock && !run_eff;
  assign ia = r_ff.status_word_one[16:0];
  // match against select address, never inside the private register range
  assign stop_hit = stop_sw && !lock && (sel_addr_sw > OPC_PRIV_TOP) &&
                    ((ia == sel_addr_sw) || r_ff.op_hit);
  assign rst_ev = ev[OPC_M_CPURST] | ev[OPC_M_SYSRST];
  assign apb_acc = psel && penable;
  assign stat_w = {28'h0, lock, r_ff.step, (r_ff.st == OPC_HALT), run_ind};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = mom_sw;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    nxt_r.start = 1'b0;
    unique case (r_ff.st)
      OPC_IDLE: begin
        if (run_eff) begin
          nxt_r.st = OPC_EXEC;
          nxt_r.start = 1'b1;
          nxt_r.op_hit = 1'b0;
        end else if (!lock && ev[OPC_M_STEP]) begin
          nxt_r.st = OPC_EXEC;
          nxt_r.step = 1'b1;
          nxt_r.start = 1'b1;
          nxt_r.op_hit = 1'b0;
        end else if (pnl_ok) begin
          if (ev[OPC_M_DCLR]) begin
            nxt_r.disp = 32'h0;
          end else if (ev[OPC_M_DENT]) begin
            nxt_r.disp = r_ff.disp | data_sw;
          end
          if (ev[OPC_M_CLR2]) begin
            nxt_r.status_word_two = r_ff.status_word_two & ~OPC_STATUS_WORD_TWO_CLR_MASK;
          end else if (ev[OPC_M_INS2]) begin
            nxt_r.status_word_two = r_ff.status_word_two | data_sw;
          end
          if (ev[OPC_M_INS1]) begin
            nxt_r.status_word_one = r_ff.status_word_one | data_sw;
          end
          if (ev[OPC_M_ST_IA] || ev[OPC_M_ST_SEL]) begin
            nxt_r.st = OPC_STORE;
            nxt_r.mreq = 1'b1;
            nxt_r.mwe = 1'b1;
            nxt_r.maddr = ev[OPC_M_ST_IA] ? ia : sel_addr_sw;
          end else if (ev[OPC_M_DS_IA] || ev[OPC_M_DS_SEL]) begin
            nxt_r.st = OPC_FETCH;
            nxt_r.mreq = 1'b1;
            nxt_r.mwe = 1'b0;
            nxt_r.pnl = 1'b1;
            nxt_r.maddr = ev[OPC_M_DS_IA] ? ia : sel_addr_sw;
          end else if (ev[OPC_M_INCR]) begin
            nxt_r.status_word_one[16:0] = ia + 17'h1;
            nxt_r.st = OPC_FETCH;
            nxt_r.mreq = 1'b1;
            nxt_r.mwe = 1'b0;
            nxt_r.pnl = 1'b1;
            nxt_r.maddr = ia + 17'h1;
          end
        end
      end
      OPC_EXEC: begin
        if (exec_in.psw_we) begin
          nxt_r.status_word_one = exec_in.status_word_one;
          nxt_r.status_word_two = exec_in.status_word_two;
        end
        if (exec_in.opnd_valid && exec_in.opnd_addr == sel_addr_sw) begin
          nxt_r.op_hit = 1'b1;
        end
        if (exec_in.done) begin
          if (exec_in.taken) begin
            nxt_r.status_word_one[16:0] = exec_in.target;
          end else if (!(hold_sw && !lock)) begin
            nxt_r.status_word_one[16:0] = ia + 17'h1;
          end else begin
            nxt_r.status_word_one[16:0] = ia;
          end
          nxt_r.st = OPC_FETCH;
          nxt_r.mreq = 1'b1;
          nxt_r.mwe = 1'b0;
          nxt_r.maddr = nxt_r.status_word_one[16:0];
        end
      end
      OPC_FETCH: begin
        if (mem_ack) begin
          nxt_r.disp = mem_rdata;
          nxt_r.mreq = 1'b0;
          nxt_r.pnl = 1'b0;
          nxt_r.step = 1'b0;
          if (r_ff.pnl || r_ff.step || !run_eff) begin
            nxt_r.st = OPC_IDLE;
          end else if (stop_hit) begin
            nxt_r.st = OPC_HALT;
          end else begin
            nxt_r.st = OPC_EXEC;
            nxt_r.start = 1'b1;
            nxt_r.op_hit = 1'b0;
          end
        end
      end
      OPC_STORE: begin
        if (mem_ack) begin
          nxt_r.mreq = 1'b0;
          nxt_r.mwe = 1'b0;
          nxt_r.st = OPC_IDLE;
        end
      end
      OPC_HALT: begin
        if (!run_eff) begin
          nxt_r.st = OPC_IDLE;
          nxt_r.op_hit = 1'b0;
        end
      end
    endcase
    // program write to the alarm register
    if (apb_acc && pwrite && paddr == OPC_REG_ALARM) begin
      nxt_r.alarm = pwdata[0];
    end
    // panel reset switches
    if (rst_ev) begin
      nxt_r.alarm = 1'b0;
      nxt_r.st = OPC_IDLE;
      nxt_r.disp = OPC_DISP_RST;
      nxt_r.status_word_one = {15'h0, OPC_IA_RST};
      nxt_r.status_word_two = 32'h0;
      nxt_r.step = 1'b0;
      nxt_r.pnl = 1'b0;
      nxt_r.mreq = 1'b0;
      nxt_r.mwe = 1'b0;
      nxt_r.start = 1'b0;
    end
    // sticky faults; a read clears only the flags it reported in its setup cycle,
    // so a fault landing between setup and access is not lost; a new fault wins
    if (rst_ev) begin
      nxt_r.fault = '0;
    end else if (apb_acc && !pwrite && paddr == OPC_REG_FAULT) begin
      nxt_r.fault = r_ff.fault & ~r_ff.rdata[OPC_BLOCKS-1:0];
    end
    nxt_r.fault = nxt_r.fault | par_err | over_temp;
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OPC_REG_DISP: nxt_r.rdata = r_ff.disp;
        OPC_REG_IA: nxt_r.rdata = {15'h0, ia};
        OPC_REG_STATUS_WORD_ONE: nxt_r.rdata = r_ff.status_word_one;
        OPC_REG_STATUS_WORD_TWO: nxt_r.rdata = r_ff.status_word_two;
        OPC_REG_FAULT: nxt_r.rdata = {24'h0, r_ff.fault};
        OPC_REG_ALARM: nxt_r.rdata = {31'h0, r_ff.alarm};
        OPC_REG_STAT: nxt_r.rdata = stat_w;
        default: nxt_r.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{st: OPC_IDLE, disp: OPC_DISP_RST, status_word_one: {15'h0, OPC_IA_RST}, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = r_ff.rdata;
  assign pready = apb_acc;
  assign pslverr = apb_acc && !reg_hit(paddr);
  assign exec_start = r_ff.start;
  assign exec_instr = r_ff.disp;
  assign int_hold = r_ff.step;
  assign mem_out = '{req: r_ff.mreq, we: r_ff.mwe, addr: r_ff.maddr, wdata: r_ff.disp};
  assign disp_out = r_ff.disp;
  assign ia_out = ia;
  assign status_word_one_out = r_ff.status_word_one;
  assign status_word_two_out = r_ff.status_word_two;
  assign run_ind = run_eff && (r_ff.st != OPC_HALT);
  assign wait_ind = (r_ff.st == OPC_HALT);
  assign fault_out = r_ff.fault;
  assign alarm_out = r_ff.alarm;
  assign panel_intr = ev[OPC_M_INTR];
  // forced maintenance settings in the locked position
  assign wdog_norm = lock | wdog_norm_sw;
  assign ilv_norm = lock | ilv_norm_sw;
  assign par_cont = lock | par_cont_sw;
  assign clk_cont = lock | clk_cont_sw;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  status_word_two_clear_a: assert property (pnl_ok && ev[OPC_M_CLR2] && !rst_ev
    |=> (r_ff.status_word_two & OPC_STATUS_WORD_TWO_CLR_MASK) == 32'h0)
    else $error("status word two not cleared");
  addr_stop_a: assert property (r_ff.st == OPC_FETCH && mem_ack && run_eff && !r_ff.pnl
    && !r_ff.step && stop_hit && !rst_ev |=> wait_ind && r_ff.disp == $past(mem_rdata))
    else $error("address match did not halt with next instruction shown");
  halt_release_a: assert property (wait_ind && !run_eff |=> r_ff.st == OPC_IDLE
    ##1 (r_ff.st == OPC_IDLE || r_ff.st == OPC_EXEC))
    else $error("match halt not released on idle");
  priv_range_a: assert property (sel_addr_sw <= OPC_PRIV_TOP && !rst_ev
    |=> r_ff.st != OPC_HALT || $past(r_ff.st) == OPC_HALT)
    else $error("halt on private register address");
  data_force_a: assert property (pnl_ok && ev[OPC_M_DENT] && !ev[OPC_M_DCLR] && !rst_ev
    |=> r_ff.disp == ($past(r_ff.disp) | $past(data_sw)))
    else $error("data enter is not a force-one merge");
  hold_addr_a: assert property (r_ff.st == OPC_EXEC && exec_in.done && !exec_in.taken
    && hold_sw && !lock && !rst_ev |=> ia == $past(ia) && mem_out.addr == ia)
    else $error("instruction address advanced under hold");
  incr_addr_a: assert property (pnl_ok && ev[OPC_M_INCR] && !ev[OPC_M_ST_IA]
    && !ev[OPC_M_ST_SEL] && !ev[OPC_M_DS_IA] && !ev[OPC_M_DS_SEL] && !rst_ev && !ev[OPC_M_INS1]
    |=> ia == $past(ia) + 17'h1 && mem_out.req && !mem_out.we && mem_out.addr == ia)
    else $error("increment did not advance and fetch");
  step_hold_a: assert property ($rose(r_ff.st == OPC_EXEC) && r_ff.step
    |-> int_hold throughout (r_ff.st == OPC_EXEC) [*2])
    else $error("interrupts not held off during step");
  fault_sticky_a: assert property ((|par_err)
    |=> (r_ff.fault & $past(par_err)) == $past(par_err))
    else $error("fault flag not set");
  alarm_reset_a: assert property (rst_ev |=> !alarm_out)
    else $error("alarm survived reset");
  lock_force_a: assert property (lock_sw |-> run_ind || wait_ind || !run_eff)
    else $error("locked key did not force run");

  run_cov_c: cover property (r_ff.st == OPC_IDLE ##1 r_ff.st == OPC_EXEC
    ##[1:20] r_ff.st == OPC_FETCH);
  halt_cov_c: cover property (r_ff.st == OPC_FETCH ##1 wait_ind);
  step_cov_c: cover property (r_ff.step && r_ff.st == OPC_FETCH && mem_ack);
  store_cov_c: cover property (r_ff.st == OPC_STORE && mem_ack);
endmodule // opc_panel
`default_nettype wire

// ==== opc_far_model.sv ====
// far-side model: cpu memory path and execution unit
// assumes opc_pkg; answers after slow+1 cycles, branch and operand from inputs
`default_nettype none
module opc_far_model
  import opc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire opc_pkg::opc_mem_t mem_out,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic exec_start,
  output opc_pkg::opc_exec_t exec_in,
  input wire logic [3:0] slow,
  input wire logic br,
  input wire logic [16:0] tgt,
  input wire logic [16:0] opa
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [int];
  logic [3:0] mc, ec;
  logic busy;
  ////////////////////////////////////////////////////////////
  // memory: ack after slow+1 request cycles, data lines scrambled while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5a5a_a5a5;
      mc <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack) begin
        mc <= mc + 4'h1;
        if (mc >= slow) begin
          mc <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_out.we) mem[int'(mem_out.addr)] = mem_out.wdata;
          mem_rdata <= mem.exists(int'(mem_out.addr)) ? mem[int'(mem_out.addr)] :
            32'h3c00_0000 ^ {15'h0, mem_out.addr};
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // execution: done with branch result and operand address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_in <= '0;
      busy <= 1'b0;
      ec <= 4'h0;
    end else begin
      exec_in.done <= 1'b0;
      exec_in.opnd_valid <= 1'b0;
      exec_in.target <= ~exec_in.target; // not valid outside done
      ec <= ec + 4'h1;
      if (exec_start) begin
        busy <= 1'b1;
        ec <= 4'h0;
      end else if (busy && ec >= slow) begin
        busy <= 1'b0;
        exec_in.done <= 1'b1;
        exec_in.taken <= br;
        exec_in.target <= tgt;
        exec_in.opnd_valid <= 1'b1;
        exec_in.opnd_addr <= opa;
      end
    end
  end
endmodule // opc_far_model
`default_nettype wire

// ==== tb_operator_panel_control.sv ====
// self-checking bench for the operator panel control block
// assumes opc_pkg, opc_panel, opc_far_model; drives at rising edges
`default_nettype none
module tb_operator_panel_control;
  timeunit 1ns;
  timeprecision 1ns;
  import opc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, br = 1'b0;
  logic pready, pslverr, mem_ack, exec_start, int_hold, run_ind, wait_ind, x_hold, e;
  logic alarm_out, panel_intr, wdog_norm, ilv_norm, par_cont, clk_cont;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, data_sw = 32'h0, d = 32'h0, prdata, exec_instr, disp_out;
  logic [31:0] status_word_one_out, status_word_two_out, mem_rdata, x_ins, q, x;
  logic [OPC_M_N-1:0] mom_sw = '0;
  logic [16:0] sel_addr_sw = 17'h0, s = 17'h0, tgt = 17'h0, opa = 17'h1ff00, ia_out, m_ia;
  logic [3:0] lvl = 4'h0, sw4 = 4'h0, mw = 4'h0, msw = 4'h0, slow = 4'h0;
  logic [OPC_BLOCKS-1:0] par_err = '0, over_temp = '0, pe = '0, ot = '0, fault_out;
  opc_exec_t exec_in;
  opc_mem_t mem_out;
  int err_count = 0, num_checks = 0, cyc = 0, n_ex = 0, n_pi = 0, n0;
  logic [31:0] mm [int];
  opc_panel opc_panel_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mom_sw(mom_sw), .data_sw(data_sw), .sel_addr_sw(sel_addr_sw),
    .run_sw(sw4[3]), .hold_sw(sw4[2]), .stop_sw(sw4[1]), .lock_sw(sw4[0]),
    .wdog_norm_sw(msw[3]), .ilv_norm_sw(msw[2]), .par_cont_sw(msw[1]), .clk_cont_sw(msw[0]),
    .par_err(par_err), .over_temp(over_temp), .exec_in(exec_in), .exec_start(exec_start),
    .exec_instr(exec_instr), .int_hold(int_hold), .mem_out(mem_out), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .disp_out(disp_out), .ia_out(ia_out), .status_word_one_out(status_word_one_out),
    .status_word_two_out(status_word_two_out), .run_ind(run_ind), .wait_ind(wait_ind), .fault_out(fault_out),
    .alarm_out(alarm_out), .panel_intr(panel_intr), .wdog_norm(wdog_norm),
    .ilv_norm(ilv_norm), .par_cont(par_cont), .clk_cont(clk_cont));
  opc_far_model opc_far_model_i (.pclk(pclk), .presetn(presetn), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .exec_start(exec_start), .exec_in(exec_in),
    .slow(slow), .br(br), .tgt(tgt), .opa(opa));
  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  // cycle limit and event monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (panel_intr === 1'b1) n_pi <= n_pi + 1;
    if (exec_start === 1'b1) begin
      n_ex <= n_ex + 1;
      x_ins <= exec_instr;
      x_hold <= int_hold;
    end
    if (cyc == 30000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w, input string m);
    num_checks++;
    if (g !== w) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, w);
    end
  endtask
  // memory contents as the model expects them
  function automatic logic [31:0] rdm(input logic [16:0] a);
    return mm.exists(int'(a)) ? mm[int'(a)] : 32'h3c00_0000 ^ {15'h0, a};
  endfunction
  // drive levels; i >= 0 also presses a momentary switch and waits for the work
  task automatic drv(input int i);
    int t;
    @(posedge pclk);
    data_sw <= d;
    sel_addr_sw <= s;
    sw4 <= lvl;
    msw <= mw;
    par_err <= pe;
    over_temp <= ot;
    t = 0;
    if (i >= 0) begin
      mom_sw[i] <= 1'b1;
      repeat (6) @(posedge pclk);
      mom_sw[i] <= 1'b0;
      while ((mem_out.req === 1'b1 || int_hold === 1'b1) && t < 80) begin
        @(posedge pclk);
        t++;
      end
      repeat (2) @(posedge pclk);
    end
    @(negedge pclk);
  endtask
  // wait for exec_start (0) or wait lamp (1)
  task automatic wt(input bit w);
    int t;
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while ((w ? wait_ind : exec_start) !== 1'b1 && t < 300);
  endtask
  // one apb transfer; result in q and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    x = $urandom(56);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(fault_out), 32'h0, "rst fault");
    chk(32'(alarm_out), 32'h0, "rst alarm");
    d = $urandom;
    drv(OPC_M_DCLR);
    chk(disp_out, 32'h0, "clear");
    drv(OPC_M_DENT);
    chk(disp_out, d, "enter");
    x = d;
    d = $urandom;
    drv(OPC_M_DENT);
    chk(disp_out, x | d, "force");
    drv(OPC_M_INS2);
    chk(status_word_two_out, d, "ins2");
    drv(OPC_M_CLR2);
    chk(status_word_two_out, d & ~OPC_STATUS_WORD_TWO_CLR_MASK, "clr2");
    d = 32'h0000_0140;
    drv(OPC_M_INS1);
    m_ia = 17'h0_0165;
    chk(status_word_one_out, 32'h0000_0165, "ins1");
    slow = 4'h3;
    s = 17'h0_0100 | 17'($urandom_range(255));
    d = $urandom;
    drv(OPC_M_DCLR);
    drv(OPC_M_DENT);
    drv(OPC_M_ST_SEL);
    mm[int'(s)] = d;
    drv(OPC_M_DCLR);
    drv(OPC_M_DS_SEL);
    chk(disp_out, d, "sel");
    drv(OPC_M_ST_IA);
    mm[int'(m_ia)] = d;
    drv(OPC_M_DCLR);
    drv(OPC_M_DS_IA);
    chk(disp_out, d, "ia");
    drv(OPC_M_INCR);
    m_ia = m_ia + 17'h1;
    chk(32'(ia_out), 32'(m_ia), "incr");
    chk(disp_out, rdm(m_ia), "incr d");
    // run with a private stop address, then stop on a real one
    x = rdm(m_ia);
    s = 17'h0_0005;
    opa = 17'h0_0005;
    lvl = 4'b1010;
    drv(-1);
    for (int k = 0; k < 3; k++) begin
      wt(0);
      chk(exec_instr, x, "run");
      m_ia = m_ia + 17'h1;
      x = rdm(m_ia);
    end
    chk(32'(wait_ind), 32'h0, "private");
    s = m_ia + 17'h1;
    drv(-1);
    wt(1);
    chk(32'(ia_out), 32'(s), "halt ia");
    chk(disp_out, rdm(s), "halt d");
    chk(32'(run_ind), 32'h0, "halt run");
    lvl = 4'h0;
    drv(-1);
    repeat (4) @(negedge pclk);
    chk(32'(wait_ind), 32'h0, "unhalt");
    // step with a taken branch, then a held step
    n0 = n_ex;
    br = 1'b1;
    tgt = 17'h0_0200 | 17'($urandom_range(255));
    drv(OPC_M_STEP);
    chk(x_ins, rdm(s), "step");
    chk(32'(x_hold), 32'h1, "inhibit");
    chk(32'(n_ex - n0), 32'h1, "once");
    chk(32'(ia_out), 32'(tgt), "branch");
    chk(disp_out, rdm(tgt), "step d");
    chk(32'(int_hold), 32'h0, "uninhibit");
    br = 1'b0;
    lvl = 4'b0100;
    n0 = n_ex;
    drv(OPC_M_STEP);
    chk(x_ins, rdm(tgt), "held");
    chk(32'(n_ex - n0), 32'h1, "held once");
    chk(32'(ia_out), 32'(tgt), "held ia");
    // fault flags and alarm
    lvl = 4'h0;
    pe = 8'h01 << $urandom_range(7);
    ot = {pe[0], pe[7:1]};
    x = 32'(pe | ot);
    drv(-1);
    pe = '0;
    drv(-1);
    chk(32'(fault_out), x, "sticky");
    apb(1'b0, OPC_REG_FAULT, 32'h0);
    chk(q, x, "fault rd");
    chk(32'(fault_out), 32'(ot), "heat");
    ot = '0;
    drv(-1);
    apb(1'b0, OPC_REG_FAULT, 32'h0);
    chk(32'(fault_out), 32'h0, "fault clr");
    pe = 8'h0f;
    drv(-1);
    pe = '0;
    drv(OPC_M_CPURST);
    chk(32'(fault_out), 32'h0, "cpu rst");
    apb(1'b1, OPC_REG_ALARM, 32'h1);
    chk(32'(alarm_out), 32'h1, "alarm");
    apb(1'b1, 12'h01c, 32'h0);
    chk(32'({e, alarm_out}), 32'h3, "unmapped");
    apb(1'b1, OPC_REG_ALARM, 32'h0);
    chk(32'(alarm_out), 32'h0, "alarm off");
    apb(1'b1, OPC_REG_ALARM, 32'h1);
    drv(OPC_M_SYSRST);
    chk(32'(alarm_out), 32'h0, "sys rst");
    // key lock
    mw = 4'($urandom);
    drv(-1);
    chk(32'({wdog_norm, ilv_norm, par_cont, clk_cont}), 32'(mw), "maint");
    lvl = 4'b0001;
    d = 32'hffff_ffff;
    drv(OPC_M_INS2);
    chk(status_word_two_out, 32'h0, "lock ins");
    chk(32'({wdog_norm, ilv_norm, par_cont, clk_cont, run_ind}), 32'h1f, "lock");
    n0 = n_pi;
    drv(OPC_M_INTR);
    chk(32'(n_pi - n0), 32'h1, "intr");
    lvl = 4'h0;
    drv(-1);
    conclude();
  end
endmodule // tb_operator_panel_control
`default_nettype wire
